// *** inc/ioe_pkg.sv ***
// Functional notes
// - After address ack, master sends command byte; device latches it as pointer.
// - Low three command bits pick one of eight registers for following data.
// - Pointer is write only and never comes back as read data.
// - Reads without a new command start where the pointer was left in its pair.
// - Input registers 00h/01h return live pin levels whatever the direction.
// - Writes to input registers are acknowledged but change nothing.
// - Input registers have no fixed reset value; they follow the pins.
// - Output registers 02h/03h set driven level of output pins only.
// - Reading an output register returns the written value, not the pin.
// - Polarity bit one inverts the pin value seen in the input register.
// - Direction bit one makes the pin a high-impedance input, zero an output.
// - Input pins have both drivers off, leaving the pin high-impedance.
// - Output pins enable the high or low driver per output bit.
// - Power-on reset release loads all registers and slave state with defaults.
// - While reset pin is low, registers and slave state stay at defaults.
// - Pins respond to outside drivers or writes only while reset pin is high.
// - Successive written bytes alternate between the two registers of a pair.
// - Successive read bytes alternate within the pair until master not-acks.
// - Answers one of two addresses by select pin; last bit one means read.
//
// Purpose: constants and types shared by the I/O expander register core
// Assumes: 100 MHz sys_clk, serial bus sampled by sys_clk
// Notes: register indices double as command codes
package ioe_pkg;
  localparam logic [2:0] IDX_IN0 = 3'h0;
  localparam logic [2:0] IDX_IN1 = 3'h1;
  localparam logic [2:0] IDX_OUT0 = 3'h2;
  localparam logic [2:0] IDX_OUT1 = 3'h3;
  localparam logic [2:0] IDX_INV0 = 3'h4;
  localparam logic [2:0] IDX_INV1 = 3'h5;
  localparam logic [2:0] IDX_DIR0 = 3'h6;
  localparam logic [2:0] IDX_DIR1 = 3'h7;
  localparam logic [2:0] PTR_RESET = 3'h0;
  localparam logic [7:0] OUT_RESET = 8'hff;
  localparam logic [7:0] INV_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic [5:0] BUS_ADDR_BASE = 6'h10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_RESET = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WR = 3'h2,
    ST_WACK = 3'h6,
    ST_RD = 3'h7,
    ST_RACK = 3'h5
  } ioe_state_t;
endpackage

// *** inc/ioe_bus_if.sv ***
// Purpose: byte events between serial slave engine and register core
// Assumes: all signals on sys_clk
// Notes: pulses last one cycle
`timescale 1ns/1ps
interface ioe_bus_if;
  logic addrWrite;
  logic wrByte;
  logic [7:0] wrData;
  logic rdByteDone;
  logic [7:0] rdData;
  logic busHold;

  modport phy (output addrWrite, wrByte, wrData, rdByteDone,
    input rdData, busHold);
  modport core (input addrWrite, wrByte, wrData, rdByteDone,
    output rdData, busHold);
endinterface

// *** src/ioe_i2c_slave.sv ***
// Purpose: bit level serial bus slave, turns bus traffic into byte events
// Assumes: scl and sda are asynchronous pins, addrSel already synchronised
// Notes: open-drain sda; sdaDriveN low pulls the line low
`timescale 1ns/1ps
module ioe_i2c_slave
  import ioe_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial pins
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaDriveN,
  input wire logic addrSel,
  // Byte events
  ioe_bus_if.phy bus
);
  ioe_state_t state, next_state;
  logic [1:0] sclMeta, sdaMeta;
  logic sclLast, sdaLast;
  logic [7:0] shift, next_shift;
  logic [3:0] cnt, next_cnt;
  logic isRead, next_isRead, mAck, next_mAck;
  logic next_sdaDriveN, next_addrWrite, next_wrByte, next_rdByteDone;
  logic sclRise, sclFall, startCond, stopCond;

  // Edges seen only on the second stage, never on the first
  assign sclRise = sclMeta[1] & ~sclLast;
  assign sclFall = ~sclMeta[1] & sclLast;
  assign startCond = sclMeta[1] & sclLast & sdaLast & ~sdaMeta[1];
  assign stopCond = sclMeta[1] & sclLast & ~sdaLast & sdaMeta[1];
  assign bus.wrData = shift;

  // Next state of the byte engine
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_cnt = cnt;
    next_isRead = isRead;
    next_mAck = mAck;
    next_sdaDriveN = sdaDriveN;
    next_addrWrite = 1'b0;
    next_wrByte = 1'b0;
    next_rdByteDone = 1'b0;
    if (bus.busHold) begin
      next_state = ST_IDLE;
      next_sdaDriveN = 1'b1;
    end else if (startCond) begin
      next_state = ST_ADDR;
      next_cnt = CNT_RESET;
      next_sdaDriveN = 1'b1;
    end else if (stopCond) begin
      next_state = ST_IDLE;
      next_sdaDriveN = 1'b1;
    end else begin
      case (state)
        ST_ADDR, ST_WR: begin
          if (sclRise) begin
            next_shift = {shift[6:0], sdaMeta[1]};
            next_cnt = cnt + 4'h1;
          end else if (sclFall && cnt == BITS_PER_BYTE) begin
            if (state == ST_WR) begin
              next_state = ST_WACK;
              next_sdaDriveN = 1'b0;
              next_wrByte = 1'b1;
            end else if (shift[7:1] == {BUS_ADDR_BASE, addrSel}) begin
              next_state = ST_AACK;
              next_isRead = shift[0];
              next_addrWrite = ~shift[0];
              next_sdaDriveN = 1'b0;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (sclFall) begin
            next_cnt = CNT_RESET;
            next_shift = bus.rdData;
            next_sdaDriveN = isRead ? bus.rdData[7] : 1'b1;
            next_state = isRead ? ST_RD : ST_WR;
          end
        end
        ST_WACK: begin
          if (sclFall) begin
            next_state = ST_WR;
            next_cnt = CNT_RESET;
            next_sdaDriveN = 1'b1;
          end
        end
        ST_RD: begin
          if (sclRise) begin
            next_cnt = cnt + 4'h1;
          end else if (sclFall) begin
            if (cnt == BITS_PER_BYTE) begin
              next_state = ST_RACK;
              next_sdaDriveN = 1'b1;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_sdaDriveN = shift[6];
            end
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            next_rdByteDone = 1'b1;
            next_mAck = ~sdaMeta[1];
          end else if (sclFall) begin
            // Not-acknowledge ends the read, the pin stays released
            next_state = mAck ? ST_RD : ST_IDLE;
            next_cnt = CNT_RESET;
            next_shift = bus.rdData;
            next_sdaDriveN = mAck ? bus.rdData[7] : 1'b1;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_sdaDriveN = 1'b1;
        end
      endcase
    end
  end

  // Registers; synchroniser stages idle high like released bus lines
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      sclMeta <= 2'h3;
      sdaMeta <= 2'h3;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
      shift <= SYNC_RESET;
      cnt <= CNT_RESET;
      isRead <= 1'b0;
      mAck <= 1'b0;
      sdaDriveN <= 1'b1;
      bus.addrWrite <= 1'b0;
      bus.wrByte <= 1'b0;
      bus.rdByteDone <= 1'b0;
    end else begin
      state <= next_state;
      sclMeta <= {sclMeta[0], sclPin};
      sdaMeta <= {sdaMeta[0], sdaPin};
      sclLast <= sclMeta[1];
      sdaLast <= sdaMeta[1];
      shift <= next_shift;
      cnt <= next_cnt;
      isRead <= next_isRead;
      mAck <= next_mAck;
      sdaDriveN <= next_sdaDriveN;
      bus.addrWrite <= next_addrWrite;
      bus.wrByte <= next_wrByte;
      bus.rdByteDone <= next_rdByteDone;
    end
  end
endmodule

// *** src/ioe_regs.sv ***
// Purpose: register core of a 16-bit two-port serial I/O expander
// Assumes: resetn is the power-on reset; resetPinN comes from outside
// Notes: pointer toggles its low bit after every data byte in either way
`timescale 1ns/1ps
module ioe_regs
  import ioe_pkg::*;
(
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic resetn,
  // External active-low reset pin
  input wire logic resetPinN,
  // Serial bus pins and address select strap
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaDriveN,
  input wire logic addrSel,
  // Port 0 pins
  input wire logic [7:0] port0In,
  output logic [7:0] port0Out,
  output logic [7:0] port0DriveN,
  // Port 1 pins
  input wire logic [7:0] port1In,
  output logic [7:0] port1Out,
  output logic [7:0] port1DriveN
);
  ioe_bus_if bus ();

  logic [15:0] pinMeta, pinSync;
  logic [1:0] rstMeta, addrMeta;
  logic held;
  logic [7:0] regFile [2:7];
  logic [7:0] next_regFile [2:7];
  logic [2:0] pointer, next_pointer;
  logic expectCmd, next_expectCmd;
  logic [15:0] pinLevel, next_pinLevel;
  logic [47:0] allRegs;

  // Read mux over the pointer; the pointer itself is never a source
  function automatic logic [7:0] regRead(input logic [2:0] idx,
    input logic [15:0] lvl, input logic [47:0] rf);
    logic [7:0] val;
    val = 8'h00;
    case (idx)
      IDX_IN0: val = lvl[7:0];
      IDX_IN1: val = lvl[15:8];
      IDX_OUT0: val = rf[7:0];
      IDX_OUT1: val = rf[15:8];
      IDX_INV0: val = rf[23:16];
      IDX_INV1: val = rf[31:24];
      IDX_DIR0: val = rf[39:32];
      IDX_DIR1: val = rf[47:40];
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  assign held = ~rstMeta[1];
  assign bus.busHold = held;
  assign allRegs = {regFile[7], regFile[6], regFile[5], regFile[4],
    regFile[3], regFile[2]};
  assign bus.rdData = regRead(pointer, pinLevel, allRegs);

  // Pins drive straight from flops: direction bit one is drive off
  assign port0Out = regFile[IDX_OUT0];
  assign port1Out = regFile[IDX_OUT1];
  assign port0DriveN = regFile[IDX_DIR0];
  assign port1DriveN = regFile[IDX_DIR1];

  ioe_i2c_slave u_slave (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sclPin(sclPin),
    .sdaPin(sdaPin),
    .sdaDriveN(sdaDriveN),
    .addrSel(addrMeta[1]),
    .bus(bus.phy)
  );

  // Two-stage synchronisers for pins, reset pin and address strap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta <= 16'h0000;
      pinSync <= 16'h0000;
      rstMeta <= 2'h0;
      addrMeta <= 2'h0;
      sdaOut <= 1'b0;
    end else begin
      // Open-drain data line only ever pulls low, kept in a flop
      sdaOut <= 1'b0;
      pinMeta <= {port1In, port0In};
      pinSync <= pinMeta;
      rstMeta <= {rstMeta[0], resetPinN};
      addrMeta <= {addrMeta[0], addrSel};
    end
  end

  // Next values of pointer, registers and sampled pin levels
  always_comb begin
    for (int i = 2; i <= 7; i++) begin
      next_regFile[i] = regFile[i];
    end
    next_pointer = pointer;
    next_expectCmd = expectCmd;
    next_pinLevel = pinLevel;
    if (held) begin
      // Pin levels freeze while the reset pin holds the device
      next_regFile[IDX_OUT0] = OUT_RESET;
      next_regFile[IDX_OUT1] = OUT_RESET;
      next_regFile[IDX_INV0] = INV_RESET;
      next_regFile[IDX_INV1] = INV_RESET;
      next_regFile[IDX_DIR0] = DIR_RESET;
      next_regFile[IDX_DIR1] = DIR_RESET;
      next_pointer = PTR_RESET;
      next_expectCmd = 1'b0;
    end else begin
      // Live pins with per-bit inversion, direction ignored
      next_pinLevel = pinSync ^ {regFile[IDX_INV1], regFile[IDX_INV0]};
      if (bus.addrWrite) begin
        next_expectCmd = 1'b1;
      end
      if (bus.wrByte) begin
        if (expectCmd) begin
          next_pointer = bus.wrData[2:0];
          next_expectCmd = 1'b0;
        end else begin
          // Input register writes are taken but dropped
          if (pointer != IDX_IN0 && pointer != IDX_IN1) begin
            next_regFile[pointer] = bus.wrData;
          end
          next_pointer = {pointer[2:1], ~pointer[0]};
        end
      end else if (bus.rdByteDone) begin
        next_pointer = {pointer[2:1], ~pointer[0]};
      end
    end
  end

  // State registers; input levels reset to zero only as a known start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regFile[IDX_OUT0] <= OUT_RESET;
      regFile[IDX_OUT1] <= OUT_RESET;
      regFile[IDX_INV0] <= INV_RESET;
      regFile[IDX_INV1] <= INV_RESET;
      regFile[IDX_DIR0] <= DIR_RESET;
      regFile[IDX_DIR1] <= DIR_RESET;
      pointer <= PTR_RESET;
      expectCmd <= 1'b0;
      pinLevel <= 16'h0000;
    end else begin
      for (int i = 2; i <= 7; i++) begin
        regFile[i] <= next_regFile[i];
      end
      pointer <= next_pointer;
      expectCmd <= next_expectCmd;
      pinLevel <= next_pinLevel;
    end
  end

  // Command byte lands in the pointer, upper bits dropped
  a_cmd_load: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && expectCmd && !held |=> pointer == $past(bus.wrData[2:0]))
    else $error("command byte not loaded into pointer");

  // Data write moves to the partner register
  a_write_pair: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && !expectCmd && !held
    |=> pointer == {$past(pointer[2:1]), ~$past(pointer[0])})
    else $error("write did not alternate within pair");

  // Each read byte moves to the partner register
  a_read_pair: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.rdByteDone && !bus.wrByte && !held
    |=> pointer[0] != $past(pointer[0]) && pointer[2:1] == $past(pointer[2:1]))
    else $error("read did not alternate within pair");

  // Writes aimed at input registers leave the stored registers untouched
  a_input_ro: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && !expectCmd && !held && pointer[2:1] == 2'b00
    |=> $stable(allRegs))
    else $error("input register write changed state");

  // Direction write reaches the pin driver enables
  a_dir_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && !expectCmd && !held && pointer == IDX_DIR0
    |=> port0DriveN == $past(bus.wrData))
    else $error("direction write not seen at drive enables");

  // Output write reaches the pin levels
  a_out_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && !expectCmd && !held && pointer == IDX_OUT1
    |=> port1Out == $past(bus.wrData))
    else $error("output write not seen at pins");

  // Reset pin holds the defaults
  a_hold_default: assert property (@(posedge sys_clk) disable iff (!resetn)
    held |=> port0DriveN == DIR_RESET && port1DriveN == DIR_RESET
    && port0Out == OUT_RESET && pointer == PTR_RESET)
    else $error("defaults not held under reset pin");

  // Input value is the synchronised pin with inversion applied
  a_invert_path: assert property (@(posedge sys_clk) disable iff (!resetn)
    !held |=> pinLevel ==
    $past(pinSync ^ {regFile[IDX_INV1], regFile[IDX_INV0]}))
    else $error("input level or inversion wrong");

  // Pins are ignored while the reset pin is low
  a_pins_frozen: assert property (@(posedge sys_clk) disable iff (!resetn)
    held |=> $stable(pinLevel))
    else $error("input levels moved under reset pin");

  // Pointer only changes on a byte event or reset pin
  a_ptr_steady: assert property (@(posedge sys_clk) disable iff (!resetn)
    !bus.wrByte && !bus.rdByteDone && !held |=> $stable(pointer))
    else $error("pointer changed without a byte");

  // Output write to port 0 reaches the pin levels
  a_out0_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && !expectCmd && !held && pointer == IDX_OUT0
    |=> port0Out == $past(bus.wrData))
    else $error("port 0 output write not seen at pins");

  // Direction write to port 1 reaches the drive enables
  a_dir1_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && !expectCmd && !held && pointer == IDX_DIR1
    |=> port1DriveN == $past(bus.wrData))
    else $error("port 1 direction write not seen");

  // Inversion write to port 0 lands in its register
  a_inv0_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && !expectCmd && !held && pointer == IDX_INV0
    |=> regFile[IDX_INV0] == $past(bus.wrData))
    else $error("port 0 inversion write lost");

  // Inversion write to port 1 lands in its register
  a_inv1_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && !expectCmd && !held && pointer == IDX_INV1
    |=> regFile[IDX_INV1] == $past(bus.wrData))
    else $error("port 1 inversion write lost");

  // Output register reads give the written value, not the pin
  a_read_out: assert property (@(posedge sys_clk) disable iff (!resetn)
    pointer == IDX_OUT0 |-> bus.rdData == port0Out)
    else $error("output register read not the stored value");

  // Direction reads come from the register, never the pointer
  a_read_dir: assert property (@(posedge sys_clk) disable iff (!resetn)
    pointer == IDX_DIR1 |-> bus.rdData == port1DriveN)
    else $error("direction register read wrong");

  // Inversion reads come from the register
  a_read_inv: assert property (@(posedge sys_clk) disable iff (!resetn)
    pointer == IDX_INV1 |-> bus.rdData == regFile[IDX_INV1])
    else $error("inversion register read wrong");

  // Input port 0 read shows the sampled level
  a_read_in0: assert property (@(posedge sys_clk) disable iff (!resetn)
    pointer == IDX_IN0 |-> bus.rdData == pinLevel[7:0])
    else $error("input port 0 read wrong");

  // Input port 1 read shows the sampled level
  a_read_in1: assert property (@(posedge sys_clk) disable iff (!resetn)
    pointer == IDX_IN1 |-> bus.rdData == pinLevel[15:8])
    else $error("input port 1 read wrong");

  // Reset pin also resets inversion, port 1 output and command flag
  a_hold_rest: assert property (@(posedge sys_clk) disable iff (!resetn)
    held |=> !expectCmd && regFile[IDX_INV0] == INV_RESET
    && regFile[IDX_INV1] == INV_RESET && port1Out == OUT_RESET)
    else $error("remaining defaults not held under reset pin");

  // Reset pin parks the slave engine with the data line released
  a_hold_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    held |=> u_slave.state == ST_IDLE && sdaDriveN)
    else $error("slave engine not idle under reset pin");

  // Write address arms the command byte
  a_cmd_arm: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.addrWrite && !held |=> expectCmd)
    else $error("write address did not arm command byte");

  // Only the first byte after the address is a command
  a_cmd_once: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wrByte && expectCmd && !held |=> !expectCmd)
    else $error("command flag stayed set after command");

  // Registers only move on a data byte or the reset pin
  a_regs_steady: assert property (@(posedge sys_clk) disable iff (!resetn)
    !bus.wrByte && !held |=> $stable(allRegs))
    else $error("registers changed without a write");

  // Data bytes never leave the selected pair
  a_pair_same: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(bus.wrByte && expectCmd) && !held
    |=> pointer[2:1] == $past(pointer[2:1]))
    else $error("pointer left its register pair");
endmodule

// *** tb/ioe_i2c_master.sv ***
// Purpose: serial bus master model facing the expander
// Assumes: bit time 16 sys_clk (160 ns), changes at falling sys_clk
// Notes: sdaOut high releases the line to the pull-up
`timescale 1ns/1ps
module ioe_i2c_master (
  // Clock
  input wire logic sys_clk,
  // Bus lines
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaOut
);
  // Clock line stands high between frames
  initial begin
    sclOut = 1'b1;
    sdaOut = 1'b1;
  end

  // Quarter bit gives 40 ns setup and hold around SCL edges
  task automatic qtr();
    repeat (4) @(negedge sys_clk);
  endtask

  // Start, also used as repeated start
  task automatic start();
    qtr();
    sdaOut = 1'b1;
    qtr();
    sclOut = 1'b1;
    qtr();
    sdaOut = 1'b0;
    qtr();
    sclOut = 1'b0;
  endtask

  task automatic stop();
    qtr();
    sdaOut = 1'b0;
    qtr();
    sclOut = 1'b1;
    qtr();
    sdaOut = 1'b1;
    qtr();
  endtask

  // One bit; sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    qtr();
    sdaOut = b;
    qtr();
    sclOut = 1'b1;
    qtr();
    r = sdaLine;
    qtr();
    sclOut = 1'b0;
  endtask

  // Byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] b, input logic ackIn,
                      output logic [7:0] r, output logic ackOut);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ackIn, ackOut);
  endtask
endmodule

// *** tb/tb.sv ***
// Purpose: self-checking bench for the I/O expander register core
// Assumes: 100 MHz sys_clk, master model on the serial pins
// Notes: output pins loop back into the pin level inputs
`timescale 1ns/1ps
module tb;
  logic sys_clk, resetn, resetPinN, sclPin, mSda, sdaLine, addrSel;
  logic sdaOut, sdaDriveN, ack;
  logic [7:0] port0In, port0Out, port0DriveN, rd;
  logic [7:0] port1In, port1Out, port1DriveN;
  logic [7:0] ext [2];
  logic [7:0] mdl [8];
  logic [2:0] ptr;
  int errors, compares, seed;

  // Open-drain data line with pull-up; pins resolve per direction
  assign sdaLine = mSda & (sdaDriveN | sdaOut);
  assign port0In = (port0DriveN & ext[0]) | (~port0DriveN & port0Out);
  assign port1In = (port1DriveN & ext[1]) | (~port1DriveN & port1Out);

  ioe_regs ioe_regs_inst (
    .sys_clk(sys_clk), .resetn(resetn), .resetPinN(resetPinN),
    .sclPin(sclPin), .sdaPin(sdaLine), .sdaOut(sdaOut),
    .sdaDriveN(sdaDriveN), .addrSel(addrSel),
    .port0In(port0In), .port0Out(port0Out), .port0DriveN(port0DriveN),
    .port1In(port1In), .port1Out(port1Out), .port1DriveN(port1DriveN)
  );
  ioe_i2c_master ioe_i2c_master_inst (
    .sys_clk(sys_clk), .sdaLine(sdaLine), .sclOut(sclPin), .sdaOut(mSda)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the planned run length
  initial begin
    repeat (95000) @(posedge sys_clk);
    errors++;
    complete_run();
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Defaults of the register table; pointer starts at 0
  function automatic void mdl_reset();
    for (int i = 2; i < 8; i++) mdl[i] = (i / 2 == 2) ? 8'h00 : 8'hff;
    ptr = 3'h0;
  endfunction

  // Pin level as resolved on the wire, then the invert mask
  function automatic logic [7:0] exp_in(input logic p);
    return ((mdl[6+p] & ext[p]) | (~mdl[6+p] & mdl[2+p])) ^ mdl[4+p];
  endfunction

  task automatic check_pins();
    check(port0Out, mdl[2]);
    check(port1Out, mdl[3]);
    check(port0DriveN, mdl[6]);
    check(port1DriveN, mdl[7]);
    check({7'h0, sdaDriveN}, 8'h01);
    check({7'h0, sdaOut}, 8'h00);
  endtask

  task automatic send_addr(input logic rw, input logic sel, input logic nak);
    ioe_i2c_master_inst.start();
    ioe_i2c_master_inst.xfer({6'h10, sel, rw}, 1'b1, rd, ack);
    check({7'h0, ack}, {7'h0, nak});
  endtask

  // Command then n random data bytes
  task automatic wr(input logic [7:0] cmd, input int n);
    logic [7:0] d;
    send_addr(1'b0, addrSel, 1'b0);
    ioe_i2c_master_inst.xfer(cmd, 1'b1, rd, ack);
    check({7'h0, ack}, 8'h00);
    ptr = cmd[2:0];
    repeat (n) begin
      d = 8'($random(seed));
      ioe_i2c_master_inst.xfer(d, 1'b1, rd, ack);
      check({7'h0, ack}, 8'h00);
      if (ptr > 3'h1) mdl[ptr] = d;
      ptr[0] = ~ptr[0];
    end
    ioe_i2c_master_inst.stop();
    repeat (4) @(negedge sys_clk);
    check_pins();
  endtask

  // Optional command and restart, then n bytes, last one not acked
  task automatic rd_regs(input int n, input logic cmdOn,
                         input logic [7:0] cmd);
    if (cmdOn) begin
      send_addr(1'b0, addrSel, 1'b0);
      ioe_i2c_master_inst.xfer(cmd, 1'b1, rd, ack);
      ptr = cmd[2:0];
    end
    send_addr(1'b1, addrSel, 1'b0);
    for (int i = 0; i < n; i++) begin
      ioe_i2c_master_inst.xfer(8'hff, i == n - 1, rd, ack);
      check(rd, ptr > 3'h1 ? mdl[ptr] : exp_in(ptr[0]));
      ptr[0] = ~ptr[0];
    end
    ioe_i2c_master_inst.stop();
  endtask

  initial begin
    seed = 32'h9251111f;
    errors = 0;
    compares = 0;
    resetn = 1'b0;
    resetPinN = 1'b1;
    addrSel = 1'b0;
    ext[0] = 8'($random(seed));
    ext[1] = 8'($random(seed));
    mdl[0] = 8'h00;
    mdl[1] = 8'h00;
    mdl_reset();
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    repeat (6) @(negedge sys_clk);
    check_pins();
    for (int c = 0; c < 8; c += 2) rd_regs(2, 1'b1, 8'(c));
    // Every command code written and read, both addresses
    for (int it = 0; it < 16; it++) begin
      addrSel = it[3];
      ext[0] = 8'($random(seed));
      ext[1] = 8'($random(seed));
      repeat (4) @(negedge sys_clk);
      wr({5'($random(seed)), 3'(it)}, 1 + it % 3);
      rd_regs(3, 1'b1, {5'($random(seed)), 3'(it + 3)});
      rd_regs(2, 1'b0, 8'h00);
    end
    // Other address is refused
    send_addr(1'b0, ~addrSel, 1'b1);
    ioe_i2c_master_inst.stop();
    // Reset pin holds defaults and blocks the bus while low
    wr(8'h02, 4);
    resetPinN = 1'b0;
    repeat (4) @(negedge sys_clk);
    mdl_reset();
    check_pins();
    send_addr(1'b0, addrSel, 1'b1);
    ioe_i2c_master_inst.stop();
    check_pins();
    resetPinN = 1'b1;
    repeat (6) @(negedge sys_clk);
    rd_regs(2, 1'b0, 8'h00);
    rd_regs(6, 1'b1, 8'h06);
    // Second power-on reset in mid-run
    wr(8'h07, 2);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    mdl_reset();
    repeat (6) @(negedge sys_clk);
    check_pins();
    rd_regs(2, 1'b1, 8'h02);
    complete_run();
  end
endmodule
